// *** relay_seq_pkg.sv ***
// Shared constants and types for the relay output sequencer
package relay_seq_pkg;

    // ==========================================================
    // Output modes and sub-modes
    // ==========================================================
    typedef enum logic [1:0] {
        MODE_MANUAL      = 2'h0,
        MODE_PULSE       = 2'h1,
        MODE_DELAY_ON    = 2'h2,
        MODE_DELAY_OFF   = 2'h3
    } out_mode_t;

    typedef enum logic {
        PULSE_CONTINUOUS = 1'h0,
        PULSE_COUNTED    = 1'h1
    } pulse_mode_t;

    typedef enum logic [1:0] {
        FAILSAFE_NONE    = 2'h0,
        FAILSAFE_ON      = 2'h1,
        FAILSAFE_OFF     = 2'h2
    } failsafe_t;

    // ==========================================================
    // Widths, reset values and timing
    // ==========================================================
    localparam int          WIDTH_BITS     = 14;
    localparam int          COUNT_BITS     = 16;
    localparam logic [13:0] WIDTH_DEFAULT  = 14'h0001;
    localparam logic [13:0] WIDTH_MAX      = 14'h270f;
    localparam logic [15:0] COUNT_DEFAULT  = 16'h0001;
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          TICK_MS        = 100;
    localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;

endpackage

// *** tick_gen.sv ***
// Timebase divider producing a one-cycle tick every period
`timescale 1ns/1ps

module tick_gen #(
    parameter int CYCLES = relay_seq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic I_CLK,
    input  wire logic I_RST,
    // Restart and tick
    input  wire logic i_restart,
    output logic      o_tick
);

    typedef struct packed {
        logic [22:0] cnt;
        logic        tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;

    // ==========================================================
    // Divider
    // ==========================================================
    // Restart aligns the first interval to the start command
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (i_restart) begin
            next_st.cnt = 23'h000000;
        end else if (st.cnt == 23'(CYCLES - 1)) begin
            next_st.cnt  = 23'h000000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 23'h000001;
        end
    end

    // State register
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;

endmodule

// *** relay_output_sequencer.sv ***
// Relay output channel sequencer: manual, pulse and delayed modes
`timescale 1ns/1ps

module relay_output_sequencer #(
    parameter int TICK_CYCLES = relay_seq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // Commands, one-cycle pulses from logic on the same clock
    input  wire logic        I_ACTIVATE,
    input  wire logic        I_DEACTIVATE,
    // Failsafe trigger, a pin from outside the clock domain
    input  wire logic        I_FAILSAFE_TRIG,
    // Configuration
    input  wire logic [1:0]  I_OUT_MODE,
    input  wire logic        I_PULSE_MODE,
    input  wire logic [15:0] I_PULSE_COUNT,
    input  wire logic [13:0] I_INACTIVE_WIDTH,
    input  wire logic [13:0] I_ACTIVE_WIDTH,
    input  wire logic [13:0] I_DELAY,
    input  wire logic [1:0]  I_FAILSAFE_ACTION,
    // Relay drive and status
    output logic             O_RELAY,
    output logic             O_BUSY,
    output logic             O_DONE
);

    // ==========================================================
    // Timing notes
    // ==========================================================
    // Every start restarts the timebase, so the first period of a run
    // lasts its ticks plus one clock; later periods are whole ticks.
    // Deactivate wins over a same-cycle activate; failsafe wins over both.
    // The failsafe pin is asynchronous and acts only on its rising edge,
    // so a trigger held high fires once and must fall to re-arm.
    // Widths are read when each period is loaded, not latched at start,
    // so a new setting takes effect at the next period boundary.
    // The pulse sub-mode is read at each inactive period end for the same reason.
    // The pulse count is latched at start; changing it mid-run is ignored.
    // Busy covers timed runs only; manual drive never raises it.
    // Done marks a run that ended by itself, never a cancel or failsafe.
    // A failsafe that lands on the same edge as a natural end keeps done.
    // Widths of zero clamp to one tick; widths above 9999 clamp to 9999.
    // A pulse count of zero runs a single active/inactive sequence.
    // Counted trains end low, after the last inactive period.
    // The timebase keeps running while idle; only a start realigns it.

    // ==========================================================
    // Sequencer state
    // ==========================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PULSE_ON,
        ST_PULSE_OFF,
        ST_DELAY_ON,
        ST_DELAY_OFF
    } seq_state_t;

    typedef struct packed {
        seq_state_t  fsm;
        logic        relay;
        logic        busy;
        logic        done;
        logic [13:0] timer;
        logic [15:0] pulses;
        logic        fs_meta;
        logic        fs_sync;
        logic        fs_prev;
    } seq_t;

    seq_t st;
    seq_t next_st;

    logic tick;
    logic start;
    logic fs_fire;

    // ==========================================================
    // Timebase
    // ==========================================================
    // Restarted on every start so the first interval is a full tick plus one clock
    tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .I_CLK     (I_CLK),
        .I_RST     (I_RST),
        .i_restart (start),
        .o_tick    (tick)
    );

    // ==========================================================
    // Command and trigger decode
    // ==========================================================
    // Start is an activate that is not also a deactivate
    assign start   = I_ACTIVATE & ~I_DEACTIVATE;
    // Rising edge of the synchronised trigger, never the first stage
    assign fs_fire = st.fs_sync & ~st.fs_prev;

    // ==========================================================
    // Width clamp into the legal 1..9999 range
    // ==========================================================
    // Zero would make a period vanish; clamp rather than misbehave
    function automatic logic [13:0] clamp_width(input logic [13:0] w);
        logic [13:0] r;
        r = w;
        if (w == 14'h0000) begin
            r = relay_seq_pkg::WIDTH_DEFAULT;
        end else if (w > relay_seq_pkg::WIDTH_MAX) begin
            r = relay_seq_pkg::WIDTH_MAX;
        end
        return r;
    endfunction

    // ==========================================================
    // Settings as used by the sequencer
    // ==========================================================
    logic [13:0] act_width;
    logic [13:0] inact_width;
    logic [13:0] delay_width;
    logic [15:0] start_count;
    logic        fs_force;
    logic        fs_level;

    // Widths kept in range so a period never vanishes or overruns
    always_comb begin
        act_width   = clamp_width(I_ACTIVE_WIDTH);
        inact_width = clamp_width(I_INACTIVE_WIDTH);
        delay_width = clamp_width(I_DELAY);
    end

    // Zero count treated as the default of one
    always_comb begin
        start_count = I_PULSE_COUNT;
        if (I_PULSE_COUNT == 16'h0000) begin
            start_count = relay_seq_pkg::COUNT_DEFAULT;
        end
    end

    // None and the spare code both leave relay and sequence alone
    always_comb begin
        fs_force = 1'b0;
        fs_level = 1'b0;
        unique case (I_FAILSAFE_ACTION)
            relay_seq_pkg::FAILSAFE_ON: begin
                fs_force = 1'b1;
                fs_level = 1'b1;
            end
            relay_seq_pkg::FAILSAFE_OFF: begin
                fs_force = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Commands first, failsafe last so it overrides a running sequence
    always_comb begin
        next_st         = st;
        next_st.done    = 1'b0;
        next_st.fs_meta = I_FAILSAFE_TRIG;
        next_st.fs_sync = st.fs_meta;
        next_st.fs_prev = st.fs_sync;

        // Cancel first: deactivate wins over a same-cycle start
        if (I_DEACTIVATE) begin
            next_st.fsm   = ST_IDLE;
            next_st.relay = 1'b0;
            next_st.busy  = 1'b0;
        end else if (start) begin
            next_st.busy = 1'b1;
            // Each timed mode loads its own first period; manual drives the relay high and ends any run
            unique case (relay_seq_pkg::out_mode_t'(I_OUT_MODE))
                relay_seq_pkg::MODE_MANUAL: begin
                    next_st.relay = 1'b1;
                    next_st.busy  = 1'b0;
                    next_st.fsm   = ST_IDLE;
                end
                relay_seq_pkg::MODE_PULSE: begin
                    next_st.relay  = 1'b1;
                    next_st.fsm    = ST_PULSE_ON;
                    next_st.timer  = act_width;
                    next_st.pulses = start_count;
                end
                relay_seq_pkg::MODE_DELAY_ON: begin
                    next_st.relay = 1'b0;
                    next_st.fsm   = ST_DELAY_ON;
                    next_st.timer = delay_width;
                end
                relay_seq_pkg::MODE_DELAY_OFF: begin
                    next_st.relay = 1'b1;
                    next_st.fsm   = ST_DELAY_OFF;
                    next_st.timer = delay_width;
                end
            endcase
        end else if (tick) begin
            // All interval counters step on the 100 ms tick
            unique case (st.fsm)
                ST_IDLE: begin
                end
                ST_PULSE_ON: begin
                    if (st.timer == 14'h0001) begin
                        next_st.relay = 1'b0;
                        next_st.fsm   = ST_PULSE_OFF;
                        next_st.timer = inact_width;
                    end else begin
                        next_st.timer = st.timer - 14'h0001;
                    end
                end
                ST_PULSE_OFF: begin
                    if (st.timer != 14'h0001) begin
                        next_st.timer = st.timer - 14'h0001;
                    end else if (I_PULSE_MODE == relay_seq_pkg::PULSE_COUNTED &&
                                 st.pulses == 16'h0001) begin
                        next_st.fsm  = ST_IDLE;
                        next_st.busy = 1'b0;
                        next_st.done = 1'b1;
                    end else begin
                        // Continuous mode never decrements to an end
                        if (I_PULSE_MODE == relay_seq_pkg::PULSE_COUNTED) begin
                            next_st.pulses = st.pulses - 16'h0001;
                        end
                        next_st.relay = 1'b1;
                        next_st.fsm   = ST_PULSE_ON;
                        next_st.timer = act_width;
                    end
                end
                ST_DELAY_ON: begin
                    if (st.timer == 14'h0001) begin
                        next_st.relay = 1'b1;
                        next_st.fsm   = ST_IDLE;
                        next_st.busy  = 1'b0;
                        next_st.done  = 1'b1;
                    end else begin
                        next_st.timer = st.timer - 14'h0001;
                    end
                end
                ST_DELAY_OFF: begin
                    if (st.timer == 14'h0001) begin
                        next_st.relay = 1'b0;
                        next_st.fsm   = ST_IDLE;
                        next_st.busy  = 1'b0;
                        next_st.done  = 1'b1;
                    end else begin
                        next_st.timer = st.timer - 14'h0001;
                    end
                end
                default: begin
                    next_st.fsm  = ST_IDLE;
                    next_st.busy = 1'b0;
                end
            endcase
        end

        // Failsafe forces a steady state and stops any sequence
        if (fs_fire && fs_force) begin
            next_st.relay = fs_level;
            next_st.fsm   = ST_IDLE;
            next_st.busy  = 1'b0;
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Reset loads the default width and count
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st        <= '0;
            st.fsm    <= ST_IDLE;
            st.timer  <= relay_seq_pkg::WIDTH_DEFAULT;
            st.pulses <= relay_seq_pkg::COUNT_DEFAULT;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs straight from state flip-flops
    // ==========================================================
    assign O_RELAY = st.relay;
    assign O_BUSY  = st.busy;
    assign O_DONE  = st.done;

endmodule

// *** relay_seq_checker.sv ***
// Port-level assertions for the relay output sequencer
`timescale 1ns/1ps

module relay_seq_checker #(
    parameter int TICK_CYCLES = 4
) (
    // Clock, reset and commands
    input  wire logic       I_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_ACTIVATE,
    input  wire logic       I_DEACTIVATE,
    input  wire logic       I_FAILSAFE_TRIG,
    input  wire logic [1:0] I_OUT_MODE,
    // Watched outputs
    input  wire logic       O_RELAY,
    input  wire logic       O_BUSY,
    input  wire logic       O_DONE
);
    // ==========================================================
    // Helpers
    // ==========================================================
    logic [2:0] trig_hist;
    logic       quiet;
    logic       go;

    // Trigger history: a failsafe edge acts three edges late and wins
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            trig_hist <= 3'h0;
        end else begin
            trig_hist <= {trig_hist[1:0], I_FAILSAFE_TRIG};
        end
    end
    assign quiet = (trig_hist == 3'h0) && !I_FAILSAFE_TRIG;
    assign go    = I_ACTIVATE && !I_DEACTIVATE && quiet;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    manual_act_a: assert property (go && I_OUT_MODE == 2'h0 |=> O_RELAY && !O_BUSY)
        else $error("manual activate misbehaved");
    pulse_start_a: assert property (go && I_OUT_MODE == 2'h1 |=> O_RELAY && O_BUSY)
        else $error("pulse start misbehaved");
    delay_on_hold_a: assert property (go && I_OUT_MODE == 2'h2 |=> !O_RELAY && O_BUSY)
        else $error("delayed-on start misbehaved");
    delay_off_start_a: assert property (go && I_OUT_MODE == 2'h3 |=> O_RELAY && O_BUSY)
        else $error("delayed-off start misbehaved");
    cancel_clears_a: assert property (I_DEACTIVATE && quiet |=> !O_RELAY && !O_BUSY)
        else $error("deactivate left relay or busy set");
    idle_hold_a: assert property (!O_BUSY && !I_ACTIVATE && !I_DEACTIVATE && quiet
        |=> $stable(O_RELAY))
        else $error("idle relay changed without a command");
    done_pulse_a: assert property (O_DONE |=> !O_DONE)
        else $error("done longer than one cycle");
    done_ends_busy_a: assert property (O_DONE |-> !O_BUSY && $past(O_BUSY))
        else $error("done without end of sequence");
endmodule

// *** relay_output_sequencer_tb_top.sv ***
// Self-checking bench with a cycle model of the relay sequencer
`timescale 1ns/1ps

module relay_output_sequencer_tb_top;
    localparam int TC = 4;
    logic        I_CLK, I_RST, I_ACTIVATE, I_DEACTIVATE, I_FAILSAFE_TRIG, I_PULSE_MODE;
    logic [1:0]  I_OUT_MODE, I_FAILSAFE_ACTION;
    logic [15:0] I_PULSE_COUNT;
    logic [13:0] I_INACTIVE_WIDTH, I_ACTIVE_WIDTH, I_DELAY;
    logic        O_RELAY, O_BUSY, O_DONE;
    logic        er, eb, ed;
    logic [2:0]  fsq;
    int          left, cnt, md, bad_count = 0, n_compared = 0, cyc = 0;

    relay_output_sequencer #(.TICK_CYCLES(TC)) uut (.I_CLK(I_CLK), .I_RST(I_RST),
        .I_ACTIVATE(I_ACTIVATE), .I_DEACTIVATE(I_DEACTIVATE),
        .I_FAILSAFE_TRIG(I_FAILSAFE_TRIG), .I_OUT_MODE(I_OUT_MODE),
        .I_PULSE_MODE(I_PULSE_MODE), .I_PULSE_COUNT(I_PULSE_COUNT),
        .I_INACTIVE_WIDTH(I_INACTIVE_WIDTH), .I_ACTIVE_WIDTH(I_ACTIVE_WIDTH),
        .I_DELAY(I_DELAY), .I_FAILSAFE_ACTION(I_FAILSAFE_ACTION),
        .O_RELAY(O_RELAY), .O_BUSY(O_BUSY), .O_DONE(O_DONE));

    // ==========================================================
    // Reference model, in clock cycles at the reduced tick
    // ==========================================================
    function automatic int cl(input logic [13:0] w);
        return (w == 14'h0000) ? 1 : ((w > 14'h270f) ? 9999 : int'(w));
    endfunction

    // Failsafe acts on the third edge after the pin rises: two sync flops, then state
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            {er, eb, ed, fsq} <= 6'h00;
            left = 0;
        end else begin
            fsq <= {fsq[1:0], I_FAILSAFE_TRIG};
            ed <= 1'b0;
            if (fsq[1] && !fsq[2] && (I_FAILSAFE_ACTION inside {2'h1, 2'h2})) begin
                er <= (I_FAILSAFE_ACTION == 2'h1);
                eb <= 1'b0;
                left = 0;
            end else if (I_DEACTIVATE) begin
                {er, eb} <= 2'h0;
                left = 0;
            end else if (I_ACTIVATE) begin
                md = int'(I_OUT_MODE);
                cnt = (I_PULSE_COUNT == 16'h0000) ? 1 : int'(I_PULSE_COUNT);
                er <= (md != 2);
                eb <= (md != 0);
                // Restarted timebase makes the first period one clock longer
                left = (md == 1) ? cl(I_ACTIVE_WIDTH) * TC + 1 : cl(I_DELAY) * TC + 1;
                if (md == 0) left = 0;
            end else if (left == 1) begin
                if (md >= 2) begin
                    er <= (md == 2);
                    {eb, ed} <= 2'h1;
                    left = 0;
                end else if (er) begin
                    er <= 1'b0;
                    left = cl(I_INACTIVE_WIDTH) * TC;
                end else if (I_PULSE_MODE && cnt == 1) begin
                    {eb, ed} <= 2'h1;
                    left = 0;
                end else begin
                    cnt = cnt - 1;
                    er <= 1'b1;
                    left = cl(I_ACTIVE_WIDTH) * TC;
                end
            end else if (left > 1) left = left - 1;
        end
    end

    // Compare every cycle where both sides are settled
    always @(negedge I_CLK) begin
        if (!I_RST) begin
            n_compared++;
            if ({O_RELAY, O_BUSY, O_DONE} !== {er, eb, ed}) begin
                bad_count++;
                $display("ERROR t=%0t dut=%h model=%h", $time, {O_RELAY, O_BUSY, O_DONE},
                         {er, eb, ed});
            end
        end
    end

    // ==========================================================
    // Clock, timeout and tasks
    // ==========================================================
    initial begin
        I_CLK = 1'b0;
        forever #10 I_CLK = ~I_CLK;
    end

    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic kick(input logic a, input logic d);
        @(posedge I_CLK);
        I_ACTIVATE <= a;
        I_DEACTIVATE <= d;
        @(posedge I_CLK);
        {I_ACTIVATE, I_DEACTIVATE} <= 2'h0;
    endtask

    // Random small widths: zero checks the clamp, short keeps the run brief
    task automatic go(input logic [1:0] m, input logic pm);
        @(posedge I_CLK);
        I_OUT_MODE <= m;
        I_PULSE_MODE <= pm;
        I_PULSE_COUNT <= 16'($urandom_range(0, 3));
        I_ACTIVE_WIDTH <= 14'($urandom_range(0, 3));
        I_INACTIVE_WIDTH <= 14'($urandom_range(0, 3));
        I_DELAY <= 14'($urandom_range(0, 3));
        kick(1'b1, 1'b0);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        void'($urandom(32'hfa862829));
        {I_ACTIVATE, I_DEACTIVATE, I_FAILSAFE_TRIG, I_PULSE_MODE} = 4'h0;
        {I_OUT_MODE, I_FAILSAFE_ACTION} = 4'h0;
        I_PULSE_COUNT = 16'h0001;
        {I_INACTIVE_WIDTH, I_ACTIVE_WIDTH, I_DELAY} = {3{14'h0001}};
        I_RST = 1'b1;
        repeat (10) @(posedge I_CLK);
        I_RST <= 1'b0;
        // Every timed mode runs out on its own, manual only sets the relay, then a cancel
        for (int r = 0; r < 24; r++) begin
            go(2'(r % 4), 1'b1);
            @(negedge I_CLK);
            for (int k = 0; k < 200 && O_BUSY !== 1'b0; k++) @(negedge I_CLK);
            n_compared++;
            if (O_BUSY !== 1'b0) begin
                bad_count++;
                $display("ERROR t=%0t busy=%h expected=%h", $time, O_BUSY, 1'b0);
            end
            repeat (3) @(posedge I_CLK);
            kick(1'b0, 1'b1);
        end
        // Continuous pulse and delayed runs cut short by cancel, restart or a clash of both
        for (int r = 0; r < 12; r++) begin
            go(2'(1 + r % 3), 1'b0);
            repeat ($urandom_range(1, 40)) @(posedge I_CLK);
            kick(1'b1, r % 2 == 0);
            repeat ($urandom_range(1, 20)) @(posedge I_CLK);
            kick(1'b0, 1'b1);
        end
        // Each failsafe action during a continuous pulse train
        for (int a = 0; a < 4; a++) begin
            I_FAILSAFE_ACTION <= 2'(a);
            go(2'h1, 1'b0);
            repeat (5) @(posedge I_CLK);
            I_FAILSAFE_TRIG <= 1'b1;
            repeat (8) @(posedge I_CLK);
            I_FAILSAFE_TRIG <= 1'b0;
            repeat (6) @(posedge I_CLK);
            kick(1'b0, 1'b1);
        end
        repeat (4) @(posedge I_CLK);
        close_out();
    end
endmodule

bind relay_output_sequencer relay_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_ACTIVATE(I_ACTIVATE), .I_DEACTIVATE(I_DEACTIVATE),
    .I_FAILSAFE_TRIG(I_FAILSAFE_TRIG), .I_OUT_MODE(I_OUT_MODE),
    .O_RELAY(O_RELAY), .O_BUSY(O_BUSY), .O_DONE(O_DONE));
